/* dv/pdn_divider_network_tb.sv */
/*
 * Self-checking testbench for the PLL divider network: registers, prescalers,
 * output divider duty and inversion, resynchronisation, feedback and bypass.
 * Assumes one 20 MHz clock, a VCO tick on every cycle and a reference toggling each cycle.
 */
`timescale 1ns/1ps
module pdn_divider_network_tb;
    logic                        hclk      = 1'b0;
    logic                        hresetn   = 1'b0;
    logic                        hsel      = 1'b0;
    logic [31:0]                 haddr     = 32'h0000_0000;
    logic [1:0]                  htrans    = 2'h0;
    logic                        hwrite    = 1'b0;
    logic [2:0]                  hsize     = 3'h2;
    logic [31:0]                 hwdata    = 32'h0000_0000;
    logic                        ref_in    = 1'b0;
    logic                        vco_tick  = 1'b1;
    logic                        freq_lock = 1'b0;
    logic                        lock_det  = 1'b0;
    logic                        hready;
    logic                        hreadyout;
    logic                        hresp;
    logic [31:0]                 hrdata;
    logic                        ref_div_pulse;
    logic                        fb_div_pulse;
    logic [pdn_pkg::NUM_DIV-1:0] clk_out;
    logic                        lock_n;
    logic                        skew_en;
    int                          n_errors    = 0;
    int                          comparisons = 0;

    // Clock, and a reference with one rising edge every two cycles.
    always #25 hclk = ~hclk;
    always @(posedge hclk) ref_in <= ~ref_in;
    assign hready = hreadyout;

    pdn_divider_network dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ref_in(ref_in),
        .vco_tick(vco_tick), .freq_lock(freq_lock), .lock_det(lock_det),
        .ref_div_pulse(ref_div_pulse), .fb_div_pulse(fb_div_pulse), .clk_out(clk_out),
        .lock_n(lock_n), .skew_en(skew_en)
    );

    // Advance one cycle and let the edge's updates land before sampling.
    task automatic step;
        @(posedge hclk);
        #1;
    endtask : step

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Single AHB-Lite transfers; the master waits for hready at each phase.
    task automatic ahb_write(input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1; haddr <= 32'(a); htrans <= 2'h2; hwrite <= 1'b1;
        do step; while (hready !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
        do step; while (hready !== 1'b1);
    endtask : ahb_write

    task automatic ahb_read(input logic [7:0] a, output logic [31:0] d);
        hsel <= 1'b1; haddr <= 32'(a); htrans <= 2'h2; hwrite <= 1'b0;
        do step; while (hready !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0;
        do step; while (hready !== 1'b1);
        d = hrdata;
        chk("hresp", {31'h0, pdn_pkg::HRESP_OKAY}, {31'h0, hresp});
    endtask : ahb_read

    // A rising edge of the frequency lock restarts the dividers at the next edge.
    task automatic resync;
        freq_lock <= 1'b1;
        step;
        freq_lock <= 1'b0;
    endtask : resync

    // Measures high time and period of one output, bounded so a stuck line cannot hang.
    task automatic measure(input int i, output int hi, output int per);
        int t;
        t = 0;
        while (clk_out[i] !== 1'b0 && t < 300) begin step; t++; end
        t = 0;
        while (clk_out[i] !== 1'b1 && t < 300) begin step; t++; end
        hi = 0;
        while (clk_out[i] === 1'b1 && hi < 300) begin step; hi++; end
        per = hi;
        while (clk_out[i] === 1'b0 && per < 300) begin step; per++; end
    endtask : measure

    task automatic gap(input bit fb, output int g);
        int t;
        t = 0;
        while ((fb ? fb_div_pulse : ref_div_pulse) !== 1'b1 && t < 400) begin step; t++; end
        g = 0;
        do begin step; g++; end while ((fb ? fb_div_pulse : ref_div_pulse) !== 1'b1 && g < 400);
    endtask : gap

    task automatic t_regs;
        logic [7:0]  ofs [3];
        logic [31:0] msk [3];
        logic [31:0] d;
        ofs = '{pdn_pkg::CTRL_OFS, pdn_pkg::PRE_OFS, pdn_pkg::VDIV_OFS};
        msk = '{pdn_pkg::CTRL_MASK, pdn_pkg::PRE_MASK, pdn_pkg::VDIV_MASK};
        for (int r = 0; r < 3; r++) begin
            ahb_read(ofs[r], d);
            chk("reset value", 32'h0000_0000, d);
            ahb_write(ofs[r], 32'hffff_ffff);
            ahb_read(ofs[r], d);
            chk("writable bits", msk[r], d);
            ahb_write(ofs[r], 32'h0000_0000);
        end
        ahb_write(8'h10, 32'hffff_ffff);
        ahb_read(8'h10, d);
        chk("unmapped read", 32'h0000_0000, d);
        ahb_read(pdn_pkg::STATUS_OFS, d);
        chk("status modes", 32'h0000_0004, {29'h0, d[10:8]});
    endtask : t_regs

    // Every divider at several ratios, plain and inverted, against the duty table.
    task automatic t_duty;
        int          codes [10];
        int          hi;
        int          per;
        int          e_per;
        int          e_hi;
        logic [31:0] v;
        codes = '{0, 2, 3, 4, 6, 31, 5, 1, 8, 10};
        for (int p = 0; p < 2; p++) begin
            v = 32'h0;
            for (int k = 0; k < 5; k++) v = v | (32'(codes[5*p+k]) << (5*k));
            ahb_write(pdn_pkg::VDIV_OFS, v);
            for (int inv = 0; inv < 2; inv++) begin
                ahb_write(pdn_pkg::CTRL_OFS, inv ? 32'h0000_01f0 : 32'h0000_0000);
                resync;
                for (int k = 0; k < 5; k++) begin
                    e_per = 2 * (codes[5*p+k] + 1);
                    e_hi  = (e_per == 2 || e_per % 4 == 0) ? e_per / 2 : e_per / 2 - 1;
                    if (inv) e_hi = e_per - e_hi;
                    measure(k, hi, per);
                    chk("divider period", 32'(e_per), 32'(per));
                    chk("divider high time", 32'(e_hi), 32'(hi));
                end
            end
        end
        ahb_write(pdn_pkg::CTRL_OFS, 32'h0000_0000);
    endtask : t_duty

    // Equal ratios stay edge-aligned after a lock-driven restart.
    task automatic t_align;
        logic [31:0] s0;
        logic [31:0] s1;
        ahb_write(pdn_pkg::VDIV_OFS, 32'h0051_14a2);
        ahb_read(pdn_pkg::STATUS_OFS, s0);
        step;
        resync;
        chk("start phase", 32'h0000_001f, {27'h0, clk_out});
        for (int t = 0; t < 36; t++) begin
            step;
            chk("equal ratio outputs", {31'h0, clk_out[0]}, {31'h0, clk_out[3]});
        end
        ahb_read(pdn_pkg::STATUS_OFS, s1);
        chk("resync count", {24'h0, s0[23:16] + 8'h01}, {24'h0, s1[23:16]});
    endtask : t_align

    // Input prescaler at both ends of its range, feedback prescaler at 3 and 32, two feedback sources.
    task automatic t_loop_div;
        int          m   [2];
        int          n   [2];
        int          sel [2];
        int          vc  [2];
        int          g;
        logic [31:0] v;
        m = '{0, 31}; n = '{2, 31}; sel = '{4, 2}; vc = '{1, 0};
        for (int e = 0; e < 2; e++) begin
            v = 32'h0;
            for (int k = 0; k < 5; k++) v = v | (32'(vc[e]) << (5*k));
            ahb_write(pdn_pkg::VDIV_OFS, v);
            ahb_write(pdn_pkg::PRE_OFS, 32'(m[e]) | (32'(n[e]) << 8));
            ahb_write(pdn_pkg::CTRL_OFS, 32'(sel[e]) << 16);
            resync;
            gap(1'b0, g);
            chk("input prescaler gap", 32'(2 * (m[e] + 1)), 32'(g));
            gap(1'b1, g);
            chk("feedback gap", 32'((n[e] + 1) * 2 * (vc[e] + 1)), 32'(g));
        end
        lock_det <= 1'b1;
        step;
        step;
        chk("lock indicator", 32'h0000_0001, {30'h0, lock_n, skew_en});
    endtask : t_loop_div

    // Bypass: the prescaled reference drives the dividers at half their ratio.
    task automatic t_bypass;
        int          hi;
        int          per;
        logic [31:0] s0;
        logic [31:0] s1;
        ahb_write(pdn_pkg::PRE_OFS, 32'h0000_0002);
        ahb_write(pdn_pkg::VDIV_OFS, 32'h0031_8c41);
        ahb_write(pdn_pkg::CTRL_OFS, 32'h0000_0001);
        measure(0, hi, per);
        chk("bypass period 4", 32'd12, 32'(per));
        measure(1, hi, per);
        chk("bypass period 6", 32'd18, 32'(per));
        chk("bypass lock and skew", 32'h0000_0002, {30'h0, lock_n, skew_en});
        ahb_read(pdn_pkg::STATUS_OFS, s0);
        chk("status bypass", 32'h0000_0001, {31'h0, s0[8]});
        step;
        resync;
        ahb_read(pdn_pkg::STATUS_OFS, s1);
        chk("no resync in bypass", {24'h0, s0[23:16]}, {24'h0, s1[23:16]});
        ahb_write(pdn_pkg::CTRL_OFS, 32'h0000_0000);
        step;
        step;
        chk("loop mode restored", 32'h0000_0001, {30'h0, lock_n, skew_en});
    endtask : t_bypass

    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test

    // The tests need about a thousand cycles; twenty thousand means a hang.
    initial begin
        #(20000 * 50);
        n_errors++;
        $display("[FAIL] watchdog expected finish seen timeout");
        end_of_test;
    end

    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        step;
        t_regs;
        t_duty;
        t_align;
        t_loop_div;
        t_bypass;
        end_of_test;
    end
endmodule : pdn_divider_network_tb

/* hdl/pdn_divider_network.sv */
/*
 * PLL divider network: input and feedback prescalers, five output dividers,
 * feedback selection, bypass routing and lock-driven resynchronisation,
 * configured over an AHB-Lite slave port.
 * Assumes the analog loop supplies a VCO tick enable, a reference level and
 * lock detector results, all synchronous to hclk.
 * Hsize is ignored: the port moves whole words only.
 */
// Chosen here: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps

// Function
// - Input prescaler divides reference by 1..32.
// - Feedback prescaler divides feedback by 1..32.
// - Five output dividers, even ratios 2..64.
// - Any output divider selectable as feedback.
// - Ratio 2 or multiple of 4: 50% duty.
// - Other even ratios give shorter high time.
// - Inverted output duty is complement.
// - Equal ratios synchronise on lock.
// - Equal ratios and settings share edges.
// - Different ratios need not align edges.
// - Inverting 50% outputs can align edges.
// - Skew limited below two VCO periods.
// - Bypass feeds prescaled reference to dividers.
// - Bypass halves each divider's effective ratio.
// - Bypass output is 2*ref/(M*V).
// - Bypass disables lock detect and skew.
// - VCO 320..640 MHz gives 5..320 MHz.
// - Frequency lock always resynchronises dividers; this design skips it in bypass.
module pdn_divider_network (
    input  wire logic                         hclk,
    input  wire logic                         hresetn,
    input  wire logic                         hsel,
    input  wire logic [31:0]                  haddr,
    input  wire logic [1:0]                   htrans,
    input  wire logic                         hwrite,
    input  wire logic [2:0]                   hsize,
    input  wire logic [31:0]                  hwdata,
    input  wire logic                         hready,
    output logic                              hreadyout,
    output logic                              hresp,
    output logic [31:0]                       hrdata,
    input  wire logic                         ref_in,
    input  wire logic                         vco_tick,
    input  wire logic                         freq_lock,
    input  wire logic                         lock_det,
    output logic                              ref_div_pulse,
    output logic                              fb_div_pulse,
    output logic [pdn_pkg::NUM_DIV-1:0]       clk_out,
    output logic                              lock_n,
    output logic                              skew_en
);

    // Short names for the package widths.
    localparam int NUM_DIV = pdn_pkg::NUM_DIV;
    localparam int VCODE_W = pdn_pkg::VCODE_W;

    logic [31:0]                  ctrl_q;
    logic [31:0]                  pre_q;
    logic [31:0]                  vdiv_q;
    logic                         wr_pend_q;
    logic [pdn_pkg::ADDR_W-1:0]   waddr_q;
    logic                         ref_q;
    logic                         flock_q;
    logic                         fb_raw_q;
    logic [pdn_pkg::RSC_W-1:0]    rsc_cnt_q;
    logic [NUM_DIV-1:0]           aligned_q;
    logic [NUM_DIV-1:0]           raw;
    logic                         bypass;
    logic [NUM_DIV-1:0]           invert;
    logic [pdn_pkg::SEL_W-1:0]    fb_sel;
    logic                         div_tick;
    logic                         resync;
    logic                         fb_raw;
    logic                         addr_ok;
    logic                         cfg_write;

    // Hsize is unused: only whole-word transfers reach this slave.
    assign addr_ok   = hsel && hready && htrans[1] == pdn_pkg::HTRANS_BUSY_BIT;
    assign hreadyout = 1'b1;
    assign hresp     = pdn_pkg::HRESP_OKAY;

    // Address phase capture; the write lands in the following data phase.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            waddr_q   <= '0;
        end else if (addr_ok) begin
            wr_pend_q <= hwrite;
            waddr_q   <= haddr[pdn_pkg::ADDR_W-1:0];
        end else if (hready) begin
            wr_pend_q <= 1'b0;
        end
    end

    // Read data is loaded at the address phase so it stands in the data phase.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= '0;
        end else if (addr_ok && !hwrite) begin
            unique case (haddr[pdn_pkg::ADDR_W-1:0])
                pdn_pkg::CTRL_OFS:   hrdata <= ctrl_q;
                pdn_pkg::PRE_OFS:    hrdata <= pre_q;
                pdn_pkg::VDIV_OFS:   hrdata <= vdiv_q;
                pdn_pkg::STATUS_OFS: begin
                    hrdata <= '0;
                    hrdata[pdn_pkg::STAT_CLK_LSB +: NUM_DIV] <= clk_out;
                    hrdata[pdn_pkg::STAT_BYPASS_BIT]         <= bypass;
                    hrdata[pdn_pkg::STAT_LOCK_BIT]           <= !lock_n;
                    hrdata[pdn_pkg::STAT_SKEW_BIT]           <= skew_en;
                    hrdata[pdn_pkg::STAT_RSC_LSB +: pdn_pkg::RSC_W] <= rsc_cnt_q;
                end
                default:             hrdata <= '0;
            endcase
        end
    end

    // Configuration registers; unmapped writes are dropped.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= pdn_pkg::CTRL_RST;
            pre_q  <= pdn_pkg::PRE_RST;
            vdiv_q <= pdn_pkg::VDIV_RST;
        end else if (wr_pend_q) begin
            if (waddr_q == pdn_pkg::CTRL_OFS) begin
                ctrl_q <= hwdata & pdn_pkg::CTRL_MASK;
            end
            if (waddr_q == pdn_pkg::PRE_OFS) begin
                pre_q <= hwdata & pdn_pkg::PRE_MASK;
            end
            if (waddr_q == pdn_pkg::VDIV_OFS) begin
                vdiv_q <= hwdata & pdn_pkg::VDIV_MASK;
            end
        end
    end

    // Writes that can spoil edge alignment.
    assign cfg_write = wr_pend_q &&
        (waddr_q == pdn_pkg::CTRL_OFS || waddr_q == pdn_pkg::VDIV_OFS);

    // Field views of the control register.
    assign bypass = ctrl_q[pdn_pkg::CTRL_BYPASS_BIT];
    assign invert = ctrl_q[pdn_pkg::CTRL_INV_LSB +: NUM_DIV];
    assign fb_sel = ctrl_q[pdn_pkg::CTRL_FBSEL_LSB +: pdn_pkg::SEL_W];

    // Edge detectors on the reference and the frequency lock result.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ref_q    <= 1'b0;
            flock_q  <= 1'b0;
            fb_raw_q <= 1'b0;
        end else begin
            ref_q    <= ref_in;
            flock_q  <= freq_lock;
            fb_raw_q <= fb_raw;
        end
    end

    // Input prescaler runs in both modes and feeds the phase detector.
    pdn_prescaler u_m_pre (
        .hclk         (hclk),
        .hresetn      (hresetn),
        .tick_i       (ref_in && !ref_q),
        .ratio_code_i (pre_q[pdn_pkg::PRE_M_LSB +: pdn_pkg::PRE_W]),
        .pulse_o      (ref_div_pulse)
    );

    // Bypass swaps the VCO for the prescaled reference at the divider input.
    assign div_tick = bypass ? ref_div_pulse : vco_tick;

    // A new frequency lock resyncs whatever the indicator mode; not in bypass.
    assign resync = freq_lock && !flock_q && !bypass;

    // Feedback tap; out-of-range selections fall back to divider zero.
    assign fb_raw = (fb_sel > pdn_pkg::FBSEL_MAX) ?
                    raw[0] : raw[fb_sel];

    // Feedback prescaler closes the loop; output ratio follows N*Vfb/(M*Vk).
    pdn_prescaler u_n_pre (
        .hclk         (hclk),
        .hresetn      (hresetn),
        .tick_i       (fb_raw && !fb_raw_q),
        .ratio_code_i (pre_q[pdn_pkg::PRE_N_LSB +: pdn_pkg::PRE_W]),
        .pulse_o      (fb_div_pulse)
    );

    // Five identical dividers share one tick and one resync, so equal codes
    // stay in step; different codes keep no edge relation.
    for (genvar k = 0; k < NUM_DIV; k++) begin : g_div
        pdn_vdiv u_vdiv (
            .hclk         (hclk),
            .hresetn      (hresetn),
            .tick_i       (div_tick),
            .step2_i      (bypass),
            .resync_i     (resync),
            .ratio_code_i (vdiv_q[k*pdn_pkg::VDIV_STRIDE +: VCODE_W]),
            .invert_i     (invert[k]),
            .raw_o        (raw[k]),
            .clk_o        (clk_out[k])
        );
    end

    // Resync counter lets software see that a lock event landed.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rsc_cnt_q <= '0;
        end else if (resync) begin
            rsc_cnt_q <= rsc_cnt_q + 8'h01;
        end
    end

    // Lock and skew are meaningless without the loop, so bypass masks them.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lock_n  <= 1'b1;
            skew_en <= 1'b0;
        end else begin
            lock_n  <= bypass || !lock_det;
            skew_en <= !bypass;
        end
    end

    // Helper: dividers resynced since the last configuration change.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            aligned_q <= '0;
        end else if (resync) begin
            aligned_q <= '1;
        end else if (cfg_write) begin
            aligned_q <= '0;
        end
    end

    // Checks run on hclk and rest during reset.
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Equal codes give equal outputs.
    for (genvar k = 1; k < NUM_DIV; k++) begin : g_chk
        equal_ratio_a: assert property (
            (aligned_q[0] && aligned_q[k] && !$past(resync)
             && vdiv_q[0 +: VCODE_W] == vdiv_q[k*pdn_pkg::VDIV_STRIDE +: VCODE_W]
             && invert[0] == invert[k]) |-> clk_out[0] == clk_out[k])
            else $error("Dividers with equal ratio drifted apart.");
    end

    // Bypass masks lock and skew.
    bypass_lock_a: assert property (
        bypass |=> lock_n && !skew_en)
        else $error("Lock or skew active in bypass.");

    // Loop mode shows the lock result.
    lock_follow_a: assert property (
        !bypass |=> lock_n == !$past(lock_det))
        else $error("Lock output ignores the lock result.");

    // Bypass freezes the resync count.
    rsc_hold_a: assert property (
        bypass |=> $stable(rsc_cnt_q))
        else $error("Resync counted in bypass.");

    // A lock rising out of bypass.
    sequence lock_event_s;
        !flock_q ##0 freq_lock ##0 !bypass;
    endsequence

    // Each lock event counts once.
    lock_resync_a: assert property (
        lock_event_s |=> rsc_cnt_q == $past(rsc_cnt_q) + 8'h01)
        else $error("Frequency lock did not resync dividers.");

    // A control write address phase.
    sequence ctrl_write_s;
        addr_ok && hwrite && haddr[pdn_pkg::ADDR_W-1:0] == pdn_pkg::CTRL_OFS;
    endsequence

    // A control write lands.
    ctrl_write_a: assert property (
        ctrl_write_s ##1 1'b1 |=> ctrl_q == ($past(hwdata) & pdn_pkg::CTRL_MASK))
        else $error("Control write not stored.");

    // Bypass ticks only on the reference.
    bypass_route_a: assert property (
        (bypass && !ref_div_pulse) |-> !div_tick)
        else $error("Divider ticked in bypass without reference pulse.");

    // Loop mode passes every VCO tick.
    loop_route_a: assert property (
        (!bypass && vco_tick) |-> div_tick)
        else $error("Divider missed a VCO tick in loop mode.");

    // Feedback follows the selection.
    fb_tap_a: assert property (
        fb_sel <= pdn_pkg::FBSEL_MAX |-> fb_raw == raw[fb_sel])
        else $error("Feedback tap off the selected divider.");

endmodule : pdn_divider_network

/* hdl/pdn_prescaler.sv */
/*
 * Integer pulse prescaler: emits one pulse per (code plus one) input ticks.
 * Assumes tick_i is a one-cycle enable synchronous to hclk.
 */
`timescale 1ns/1ps
module pdn_prescaler (
    input  wire logic                      hclk,
    input  wire logic                      hresetn,
    input  wire logic                      tick_i,
    input  wire logic [pdn_pkg::PRE_W-1:0] ratio_code_i,
    output logic                           pulse_o
);

    localparam int PER_W = pdn_pkg::PER_W;

    logic [pdn_pkg::PRE_W-1:0] cnt_q;
    logic [pdn_pkg::PER_W-1:0] seen_q;
    logic [pdn_pkg::PRE_W-1:0] code_q;
    logic                      clean_q;

    // Count ticks; a code lowered below the count wraps on the next tick, never hangs.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q   <= '0;
            pulse_o <= 1'b0;
        end else begin
            pulse_o <= 1'b0;
            if (tick_i) begin
                if (cnt_q >= ratio_code_i) begin
                    cnt_q   <= '0;
                    pulse_o <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + 5'h01;
                end
            end
        end
    end

    // Helper: ticks seen since the last pulse, for the ratio check. A code
    // change spoils the running count until the next pulse restarts it.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seen_q  <= '0;
            code_q  <= '0;
            clean_q <= 1'b1;
        end else begin
            code_q  <= ratio_code_i;
            clean_q <= pulse_o || (clean_q && ratio_code_i == code_q);
            if (pulse_o) begin
                seen_q <= PER_W'(tick_i);
            end else if (tick_i) begin
                seen_q <= seen_q + 7'h01;
            end
        end
    end

    ratio_count_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (pulse_o && clean_q)
        |-> seen_q == PER_W'(code_q) + 7'h01)
        else $error("Prescaler pulse after wrong tick count.");

endmodule : pdn_prescaler

/* hdl/pdn_vdiv.sv */
/*
 * Even-ratio output divider with documented duty cycle and inversion.
 * Assumes tick_i is a one-cycle enable; step2_i doubles the advance per tick.
 */
`timescale 1ns/1ps
module pdn_vdiv (
    input  wire logic                        hclk,
    input  wire logic                        hresetn,
    input  wire logic                        tick_i,
    input  wire logic                        step2_i,
    input  wire logic                        resync_i,
    input  wire logic [pdn_pkg::VCODE_W-1:0] ratio_code_i,
    input  wire logic                        invert_i,
    output logic                             raw_o,
    output logic                             clk_o
);

    logic [pdn_pkg::CNT_W-1:0] cnt_q;
    logic [pdn_pkg::CNT_W-1:0] cnt_d;
    logic [pdn_pkg::PER_W-1:0] period;
    logic [pdn_pkg::PER_W-1:0] high;
    logic [pdn_pkg::PER_W-1:0] nxt;

    // Next phase; the double step in bypass halves the effective ratio.
    always_comb begin
        period = pdn_pkg::pdn_v_period(ratio_code_i);
        high   = pdn_pkg::pdn_v_high(ratio_code_i);
        nxt    = {1'b0, cnt_q} + (step2_i ? 7'h02 : 7'h01);
        cnt_d  = cnt_q;
        if (resync_i) begin
            cnt_d = '0;
        end else if (tick_i) begin
            cnt_d = (nxt >= period) ? '0 : nxt[pdn_pkg::CNT_W-1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // Output from flops; inversion gives the complementary duty cycle.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            raw_o <= 1'b0;
            clk_o <= 1'b0;
        end else begin
            raw_o <= ({1'b0, cnt_d} < high);
            clk_o <= ({1'b0, cnt_d} < high) ^ invert_i;
        end
    end

    resync_phase_a: assert property (@(posedge hclk) disable iff (!hresetn)
        resync_i |=> cnt_q == '0 ##0 raw_o)
        else $error("Divider not at start phase after resync.");

    phase_range_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ($past(tick_i) && $stable(ratio_code_i)) |-> {1'b0, cnt_q} < period)
        else $error("Divider phase beyond its period.");

    period_wrap_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (tick_i && !resync_i && !step2_i && {1'b0, cnt_q} == period - 7'h01)
        |=> cnt_q == '0)
        else $error("Divider did not wrap at its period.");

endmodule : pdn_vdiv

/* shared/pdn_pkg.sv */
/*
 * Shared constants for the PLL divider network: register map, field
 * layout, reset values and divider decoding helpers.
 * Assumes a 32-bit AHB-Lite register port with word-aligned registers.
 */
package pdn_pkg;

    // Divider network shape.
    localparam int NUM_DIV  = 5;
    localparam int PRE_W    = 5;
    localparam int VCODE_W  = 5;
    localparam int CNT_W    = 6;
    localparam int PER_W    = 7;
    localparam int SEL_W    = 3;
    localparam int RSC_W    = 8;
    localparam int ADDR_W   = 8;

    // Register byte offsets.
    localparam logic [ADDR_W-1:0] CTRL_OFS   = 8'h00;
    localparam logic [ADDR_W-1:0] PRE_OFS    = 8'h04;
    localparam logic [ADDR_W-1:0] VDIV_OFS   = 8'h08;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h0c;

    // Control register fields.
    localparam int CTRL_BYPASS_BIT = 0;
    localparam int CTRL_INV_LSB    = 4;
    localparam int CTRL_FBSEL_LSB  = 16;
    localparam logic [31:0] CTRL_MASK = 32'h0007_01f1;

    // Prescaler register fields: ratio minus one.
    localparam int PRE_M_LSB = 0;
    localparam int PRE_N_LSB = 8;
    localparam logic [31:0] PRE_MASK = 32'h0000_1f1f;

    // Output divider codes: ratio is two times (code plus one).
    localparam int VDIV_STRIDE = 5;
    localparam logic [31:0] VDIV_MASK = 32'h01ff_ffff;

    // Status register fields.
    localparam int STAT_CLK_LSB    = 0;
    localparam int STAT_BYPASS_BIT = 8;
    localparam int STAT_LOCK_BIT   = 9;
    localparam int STAT_SKEW_BIT   = 10;
    localparam int STAT_RSC_LSB    = 16;

    // Reset values: every ratio at its smallest setting, loop mode.
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] PRE_RST  = 32'h0000_0000;
    localparam logic [31:0] VDIV_RST = 32'h0000_0000;

    // Bus encodings and the feedback selection limit.
    localparam logic       HTRANS_BUSY_BIT = 1'b1;
    localparam logic       HRESP_OKAY      = 1'b0;
    localparam logic [SEL_W-1:0] FBSEL_MAX = 3'h4;

    // Output divider period in source ticks.
    function automatic logic [PER_W-1:0] pdn_v_period(input logic [VCODE_W-1:0] code);
        pdn_v_period = PER_W'({code, 1'b0}) + 7'h02;
    endfunction : pdn_v_period

    // High time: half the period for 2 and multiples of 4, else one short.
    function automatic logic [PER_W-1:0] pdn_v_high(input logic [VCODE_W-1:0] code);
        logic [PER_W-1:0] p;
        p = pdn_v_period(code);
        if (p == 7'h02 || p[1:0] == 2'h0) begin
            pdn_v_high = p >> 1;
        end else begin
            pdn_v_high = (p >> 1) - 7'h01;
        end
    endfunction : pdn_v_high

endpackage : pdn_pkg
